//--- tcr_timer.sv
// 16-bit timer with prescaler, gate, event input, reload and four compare pins
//
// Overview of operation
// - four compare channels match a 16-bit value against the timer, driving pins
// - 16-bit counter; wrap from all ones to zero sets overflow flag
// - timer mode counts oscillator divided by six or twelve, software selected
// - gated mode counts only while the gate input is high
// - gated mode samples the gate input once each machine cycle
// - event mode samples each machine cycle, counts on high-to-low change
// - reload mode 0: on wrap set overflow and load the reload value
// - reload mode 1: falling trigger edge loads the reload value
// - trigger falling edge sets external reload flag only when enabled
// - each channel compares its value with the counter; match acts, may interrupt
// - compare mode 0: match drives pin high, overflow drives it low
// - compare mode 0 ignores software port writes
// - compare mode 1: software writes a shadow, copied to pin at match
// - mode 1: equal level keeps pin, opposite level toggles at match
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_timer (
  // clock, reset and freeze
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        ce,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // pins
  input  wire  logic        gate_count_input,
  input  wire  logic        reload_trigger_input,
  output logic [3:0]        compare_out,
  // interrupt
  output logic              irq
);
  import tcr_pkg::*;

  localparam int NCH = 4;

  // registers
  logic [`TCR_CTRL_WIDTH-1:0] timer_control_register;
  logic [`TCR_ST_WIDTH-1:0]   interrupt_request_register;
  logic [`TCR_ST_WIDTH-1:0]   interrupt_enable_register_b;
  logic [15:0]                count;
  logic [15:0]                reload_value;
  logic [7:0]                 cmp_mode;
  logic [15:0]                cmp_value [NCH];

  // bus handshake
  logic        data_ok;
  logic        done;
  logic        wr_done;
  logic        mapped;
  logic [31:0] next_prdata;

  // timing and inputs
  logic [2:0]    phase;
  logic          mc_tick;
  logic          half;
  logic          gate_meta;
  logic          gate_sync;
  logic          gate_smp;
  logic          trig_meta;
  logic          trig_sync;
  logic          trig_smp;
  logic          trig_fall;
  tcr_ev_state_t ev_state;
  tcr_ev_state_t next_ev_state;
  logic          ev_fall;
  logic          cnt_en;
  logic          wrap;
  tcr_src_t      src;
  logic          ext_reload;

  // channel traffic
  tcr_count_evt_t       evt;
  tcr_chan_cfg_t [NCH-1:0] chan_cfg;
  logic [NCH-1:0]       chan_match;
  logic                 ev_new;
  logic                 ev_ovf;
  logic                 port_wr;
  logic [`TCR_ST_WIDTH-1:0] status_set;

  assign src = tcr_src_t'(timer_control_register[`TCR_CTRL_SRC_HI:`TCR_CTRL_SRC_LO]);

  // ---------------------------------------------------------------- apb
  // read data is captured while the request waits, so pready can go high
  // one cycle after setup; a frozen block simply holds the access phase
  assign pready  = ce && data_ok;
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite && mapped;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `TCR_OFF_CTRL:    next_prdata = {26'h0, timer_control_register};
      `TCR_OFF_STATUS:  next_prdata = {26'h0, interrupt_request_register};
      `TCR_OFF_MASK:    next_prdata = {26'h0, interrupt_enable_register_b};
      `TCR_OFF_COUNT:   next_prdata = {16'h0, count};
      `TCR_OFF_RELOAD:  next_prdata = {16'h0, reload_value};
      `TCR_OFF_CMPMODE: next_prdata = {24'h0, cmp_mode};
      `TCR_OFF_PORT:    next_prdata = {28'h0, compare_out};
      `TCR_OFF_CMP0:    next_prdata = {16'h0, cmp_value[0]};
      `TCR_OFF_CMP1:    next_prdata = {16'h0, cmp_value[1]};
      `TCR_OFF_CMP2:    next_prdata = {16'h0, cmp_value[2]};
      `TCR_OFF_CMP3:    next_prdata = {16'h0, cmp_value[3]};
      default: begin
        next_prdata = 32'h0;
        mapped      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ok <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      if (done) begin
        data_ok <= 1'b0;
      end else if (psel && !data_ok) begin
        data_ok <= 1'b1;
        prdata  <= next_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_register      <= `TCR_RST_CTRL;
      interrupt_enable_register_b <= `TCR_RST_MASK;
      reload_value                <= `TCR_RST_RELOAD;
      cmp_mode                    <= `TCR_RST_CMPMODE;
    end else if (ce && wr_done) begin
      case (paddr)
        `TCR_OFF_CTRL:    timer_control_register      <= pwdata[`TCR_CTRL_WIDTH-1:0];
        `TCR_OFF_MASK:    interrupt_enable_register_b <= pwdata[`TCR_ST_WIDTH-1:0];
        `TCR_OFF_RELOAD:  reload_value                <= pwdata[15:0];
        `TCR_OFF_CMPMODE: cmp_mode                    <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        cmp_value[i] <= `TCR_RST_CMPVAL;
      end
    end else if (ce && wr_done) begin
      for (int i = 0; i < NCH; i++) begin
        if (paddr == (`TCR_OFF_CMP0 + 8'(4 * i))) begin
          cmp_value[i] <= pwdata[15:0];
        end
      end
    end
  end

  assign port_wr = wr_done && (paddr == `TCR_OFF_PORT);

  // ---------------------------------------------------------------- machine cycle
  assign mc_tick = ce && (phase == `TCR_PHASE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
      half  <= 1'b0;
    end else if (ce) begin
      phase <= mc_tick ? 3'h0 : phase + 3'h1;
      if (mc_tick) begin
        half <= ~half;
      end
    end
  end

  // pins are asynchronous; only the second stage feeds any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_meta <= 1'b0;
      gate_sync <= 1'b0;
      trig_meta <= 1'b1;
      trig_sync <= 1'b1;
    end else if (ce) begin
      gate_meta <= gate_count_input;
      gate_sync <= gate_meta;
      trig_meta <= reload_trigger_input;
      trig_sync <= trig_meta;
    end
  end

  // one sample per machine cycle for gate and trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_smp <= 1'b0;
      trig_smp <= 1'b1;
    end else if (mc_tick) begin
      gate_smp <= gate_sync;
      trig_smp <= trig_sync;
    end
  end

  assign trig_fall = mc_tick && trig_smp && !trig_sync;

  // ---------------------------------------------------------------- event edge
  // a fall needs a high sample and a low sample in two machine cycles
  always_comb begin
    next_ev_state = ev_state;
    ev_fall       = 1'b0;
    case (ev_state)
      TCR_EV_HIGH: begin
        if (mc_tick && !gate_sync) begin
          next_ev_state = TCR_EV_LOW;
          ev_fall       = 1'b1;
        end
      end
      TCR_EV_LOW: begin
        if (mc_tick && gate_sync) begin
          next_ev_state = TCR_EV_HIGH;
        end
      end
      default: next_ev_state = TCR_EV_LOW;
    endcase
  end

  // faster sources are missed unless each level is held a full machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_state <= TCR_EV_LOW;
    end else if (ce) begin
      ev_state <= next_ev_state;
    end
  end

  // ---------------------------------------------------------------- counter
  always_comb begin
    case (src)
      TCR_SRC_TIMER: begin
        cnt_en = mc_tick && (!timer_control_register[`TCR_CTRL_DIV12] || half);
      end
      TCR_SRC_GATED: begin
        cnt_en = mc_tick && (!timer_control_register[`TCR_CTRL_DIV12] || half)
                 && gate_smp;
      end
      TCR_SRC_EVENT: cnt_en = ev_fall;
      default:       cnt_en = 1'b0;
    endcase
  end

  assign wrap       = cnt_en && (count == `TCR_COUNT_MAX);
  assign ext_reload = trig_fall && timer_control_register[`TCR_CTRL_RLD_EN]
                      && timer_control_register[`TCR_CTRL_RLD_MODE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `TCR_RST_COUNT;
    end else if (ce) begin
      if (wr_done && (paddr == `TCR_OFF_COUNT)) begin
        count <= pwdata[15:0];
      end else if (ext_reload) begin
        count <= reload_value;
      end else if (wrap) begin
        if (timer_control_register[`TCR_CTRL_RLD_EN]
            && !timer_control_register[`TCR_CTRL_RLD_MODE]) begin
          count <= reload_value;
        end else begin
          count <= 16'h0000;
        end
      end else if (cnt_en) begin
        count <= count + 16'h0001;
      end
    end
  end

  // hardware moves of the count, seen by the channels one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_new <= 1'b0;
      ev_ovf <= 1'b0;
    end else if (ce) begin
      ev_new <= cnt_en || ext_reload;
      // a trigger reload on the wrap edge replaces the wrap, so no overflow
      ev_ovf <= wrap && !ext_reload;
    end
  end

  // one driver for the whole struct; the channels read it as a unit
  assign evt = {ev_new, ev_ovf, count};

  // ---------------------------------------------------------------- compare
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_chan
      assign chan_cfg[g].enable = cmp_mode[`TCR_CMP_EN_LO + g];
      assign chan_cfg[g].mode   = cmp_mode[`TCR_CMP_MODE_LO + g];
      assign chan_cfg[g].value  = cmp_value[g];
      tcr_cmp_chan u_chan (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .cfg     (chan_cfg[g]),
        .evt     (evt),
        .sw_wr   (port_wr),
        .sw_bit  (pwdata[g]),
        .match   (chan_match[g]),
        .pin     (compare_out[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------- interrupts
  always_comb begin
    status_set                 = '0;
    status_set[`TCR_ST_OVF]    = evt.overflow;
    status_set[`TCR_ST_EXT]    = trig_fall && timer_control_register[`TCR_CTRL_EXT_EN];
    status_set[`TCR_ST_MATCH_LO +: NCH] = chan_match;
  end

  // a set in the cycle of a clear wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request_register <= `TCR_RST_STATUS;
    end else if (ce) begin
      if (wr_done && (paddr == `TCR_OFF_STATUS)) begin
        interrupt_request_register <= (interrupt_request_register
                                       & ~pwdata[`TCR_ST_WIDTH-1:0]) | status_set;
      end else begin
        interrupt_request_register <= interrupt_request_register | status_set;
      end
    end
  end

  assign irq = |(interrupt_request_register & interrupt_enable_register_b);

endmodule
`default_nettype wire

//--- tcr_cfg.svh
// offsets, field positions, reset values and timing counts of the timer block
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// register byte offsets
`define TCR_OFF_CTRL    8'h00
`define TCR_OFF_STATUS  8'h04
`define TCR_OFF_MASK    8'h08
`define TCR_OFF_COUNT   8'h0c
`define TCR_OFF_RELOAD  8'h10
`define TCR_OFF_CMPMODE 8'h14
`define TCR_OFF_PORT    8'h18
`define TCR_OFF_CMP0    8'h20
`define TCR_OFF_CMP1    8'h24
`define TCR_OFF_CMP2    8'h28
`define TCR_OFF_CMP3    8'h2c

// control register fields
`define TCR_CTRL_SRC_LO   0
`define TCR_CTRL_SRC_HI   1
`define TCR_CTRL_DIV12    2
`define TCR_CTRL_RLD_EN   3
`define TCR_CTRL_RLD_MODE 4
`define TCR_CTRL_EXT_EN   5
`define TCR_CTRL_WIDTH    6

// status and mask fields
`define TCR_ST_OVF       0
`define TCR_ST_EXT       1
`define TCR_ST_MATCH_LO  2
`define TCR_ST_WIDTH     6

// compare mode register fields
`define TCR_CMP_EN_LO    0
`define TCR_CMP_MODE_LO  4

// reset values
`define TCR_RST_CTRL     6'h00
`define TCR_RST_STATUS   6'h00
`define TCR_RST_MASK     6'h00
`define TCR_RST_COUNT    16'h0000
`define TCR_RST_RELOAD   16'h0000
`define TCR_RST_CMPVAL   16'h0000
`define TCR_RST_CMPMODE  8'h00

// oscillator periods per machine cycle, last phase and counter top
`define TCR_OSC_PER_MC   6
`define TCR_PHASE_LAST   3'h5
`define TCR_COUNT_MAX    16'hffff

`endif

//--- tcr_pkg.sv
// types shared by the timer block and its compare channels
`default_nettype none
package tcr_pkg;

  typedef enum logic [1:0] {
    TCR_SRC_STOP  = 2'h0,
    TCR_SRC_TIMER = 2'h1,
    TCR_SRC_GATED = 2'h2,
    TCR_SRC_EVENT = 2'h3
  } tcr_src_t;

  typedef enum logic [1:0] {
    TCR_EV_HIGH = 2'b01,
    TCR_EV_LOW  = 2'b10
  } tcr_ev_state_t;

  typedef struct packed {
    logic        enable;
    logic        mode;
    logic [15:0] value;
  } tcr_chan_cfg_t;

  typedef struct packed {
    logic        count_new;
    logic        overflow;
    logic [15:0] count;
  } tcr_count_evt_t;

endpackage
`default_nettype wire

//--- tcr_cmp_chan.sv
// one compare channel: match detector, port latch and shadow latch
`timescale 1ns/100ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_cmp_chan (
  // clock and reset
  input  wire  logic                   pclk,
  input  wire  logic                   presetn,
  input  wire  logic                   ce,
  // configuration and timer events
  input  wire  tcr_pkg::tcr_chan_cfg_t cfg,
  input  wire  tcr_pkg::tcr_count_evt_t evt,
  // software port write
  input  wire  logic                   sw_wr,
  input  wire  logic                   sw_bit,
  // results
  output logic                         match,
  output logic                         pin
);
  import tcr_pkg::*;

  logic shadow;

  // a match counts only when the timer has just moved onto the value
  assign match = cfg.enable && evt.count_new && (evt.count == cfg.value);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= 1'b0;
    end else if (ce && sw_wr) begin
      shadow <= sw_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
    end else if (ce) begin
      if (!cfg.enable) begin
        if (sw_wr) begin
          pin <= sw_bit;
        end
      end else if (!cfg.mode) begin
        // software writes have no path here in this mode
        if (match) begin
          pin <= 1'b1;
        end else if (evt.overflow) begin
          pin <= 1'b0;
        end
      end else if (match) begin
        // equal shadow leaves the pin as is, opposite makes an edge
        pin <= (sw_wr) ? sw_bit : shadow;
      end
    end
  end

endmodule
`default_nettype wire

//--- tcr_pins_model.sv
// pin-side model: gate or count source and reload trigger source
`timescale 1ns/100ps
`default_nettype none
module tcr_pins_model (
  // clock
  input  wire logic pclk,
  // driven pins
  output logic      gate_count_input,
  output logic      reload_trigger_input
);
  initial begin
    gate_count_input = 1'b0;
    reload_trigger_input = 1'b1;
  end
  task automatic set_gate(input logic v);
    @(posedge pclk) gate_count_input <= v;
  endtask
  // hold in pclk cycles; six is one machine cycle, the shortest legal level
  task automatic pulse_gate(input int n, input int hold);
    repeat (n) begin
      @(posedge pclk) gate_count_input <= 1'b0;
      repeat (hold - 1) @(posedge pclk);
      @(posedge pclk) gate_count_input <= 1'b1;
      repeat (hold - 1) @(posedge pclk);
    end
  endtask
  task automatic fall_trigger;
    @(posedge pclk) reload_trigger_input <= 1'b0;
    repeat (12) @(posedge pclk);
    reload_trigger_input <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- tcr_timer_asserts.sv
// port-level checks for the timer block, bound into it
`timescale 1ns/100ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_timer_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic [3:0]  compare_out,
  input wire logic        irq
);
  import tcr_pkg::*;
  logic [2:0] phase;
  logic       mc_tick;
  logic       wr_done;
  logic       mapped;
  assign mc_tick = ce && (phase == `TCR_PHASE_LAST);
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped  = (paddr[1:0] == 2'h0) &&
                   ((paddr <= `TCR_OFF_PORT) ||
                    (paddr >= `TCR_OFF_CMP0 && paddr <= `TCR_OFF_CMP3));
  // copy of the machine-cycle divider, so pin and flag moves tie to ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
    end else if (mc_tick) begin
      phase <= 3'h0;
    end else if (ce) begin
      phase <= phase + 3'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_frozen: assert property (!ce |-> !pready)
    else $error("pready high with ce low");
  a_ready_phase: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_zero_wait: assert property ((psel && !penable && ce) ##1 (psel && penable && ce) |-> pready)
    else $error("access phase not answered at once");
  a_slverr_map: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr does not follow the address map");
  a_rdata_width: assert property (psel && penable && pready && !pwrite |->
    prdata[31:16] == 16'h0 && (mapped || prdata == 32'h0))
    else $error("read data wider than sixteen bits");
  a_pin_cause: assert property ($changed(compare_out) |->
    $past(mc_tick, 2) || $past(wr_done) || $past(wr_done, 2))
    else $error("compare pin moved without match, overflow or port write");
  a_irq_cause: assert property ($rose(irq) |->
    $past(mc_tick) || $past(mc_tick, 2) || $past(wr_done))
    else $error("interrupt rose without an event or write");
  a_irq_sticky: assert property ($fell(irq) |-> $past(wr_done))
    else $error("interrupt fell without a write");
endmodule
bind tcr_timer tcr_timer_asserts u_asserts (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .compare_out, .irq);
`default_nettype wire

//--- tcr_timer_tb.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_timer_tb;
  import tcr_pkg::*;
  typedef struct packed {
    logic [5:0]  ctrl;
    logic        gate;
    logic [15:0] count;
  } tcr_row_t;
  // count over a 60-cycle window, ten machine cycles
  tcr_row_t    rows [6] = '{'{6'h01, 1'b0, 16'h000a}, '{6'h05, 1'b0, 16'h0005},
    '{6'h00, 1'b0, 16'h0000}, '{6'h02, 1'b0, 16'h0000}, '{6'h02, 1'b1, 16'h000a},
    '{6'h03, 1'b1, 16'h0000}};
  logic [7:0]  offs [4] = '{`TCR_OFF_CTRL, `TCR_OFF_STATUS, `TCR_OFF_COUNT, `TCR_OFF_CMPMODE};
  logic        pclk = 1'b0;
  logic        presetn, ce, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        gate_count_input, reload_trigger_input;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  compare_out;
  int          failures, checks_done, n;
  always #2 pclk = ~pclk;
  tcr_timer u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .gate_count_input, .reload_trigger_input, .compare_out, .irq);
  tcr_pins_model u_pins (.pclk, .gate_count_input, .reload_trigger_input);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pready, prdata and pslverr are taken at the completing rising edge;
  // the design's flops update after this process reads, so pre-edge values are seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic irq_is(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  task automatic wait_irq;
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(negedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      u_pins.set_gate(rows[i].gate);
      wr(`TCR_OFF_CTRL, {26'h0, rows[i].ctrl});
      repeat (24) @(posedge pclk);
      wr(`TCR_OFF_COUNT, 32'h0);
      // stop write completes 60 edges after the count write
      repeat (57) @(posedge pclk);
      wr(`TCR_OFF_CTRL, 32'h0);
      rdc("window count", `TCR_OFF_COUNT, {16'h0, rows[i].count});
    end
    $display("test count sources done");
    wr(`TCR_OFF_CTRL, 32'h3);
    u_pins.pulse_gate(5, 6);
    wr(`TCR_OFF_CTRL, 32'h0);
    rdc("event count", `TCR_OFF_COUNT, 32'h5);
    // ce low for 30 edges must add no ticks to the 60-edge window
    wr(`TCR_OFF_CTRL, 32'h1);
    wr(`TCR_OFF_COUNT, 32'h0);
    ce <= 1'b0;
    repeat (30) @(posedge pclk);
    ce <= 1'b1;
    repeat (57) @(posedge pclk);
    wr(`TCR_OFF_CTRL, 32'h0);
    rdc("frozen count", `TCR_OFF_COUNT, 32'ha);
    $display("test clock enable done");
    wr(`TCR_OFF_RELOAD, 32'h4321);
    wr(`TCR_OFF_MASK, 32'h2);
    wr(`TCR_OFF_CTRL, 32'h38);
    u_pins.fall_trigger();
    rdc("trigger reload", `TCR_OFF_COUNT, 32'h4321);
    repeat (30) @(posedge pclk);
    rdc("ext flag", `TCR_OFF_STATUS, 32'h2);
    irq_is(1'b1);
    wr(`TCR_OFF_MASK, 32'h0);
    irq_is(1'b0);
    wr(`TCR_OFF_STATUS, 32'h2);
    wr(`TCR_OFF_MASK, 32'h2);
    irq_is(1'b0);
    wr(`TCR_OFF_CTRL, 32'h18);
    wr(`TCR_OFF_COUNT, 32'h0);
    u_pins.fall_trigger();
    rdc("reload, flag off", `TCR_OFF_COUNT, 32'h4321);
    rdc("flag off", `TCR_OFF_STATUS, 32'h0);
    $display("test trigger reload done");
    wr(`TCR_OFF_MASK, 32'h1);
    wr(`TCR_OFF_RELOAD, 32'hfff0);
    wr(`TCR_OFF_COUNT, 32'hfffe);
    wr(`TCR_OFF_CTRL, 32'h09);
    wait_irq();
    rdc("auto reload", `TCR_OFF_COUNT, 32'hfff0);
    wr(`TCR_OFF_CTRL, 32'h0);
    rdc("overflow flag", `TCR_OFF_STATUS, 32'h1);
    wr(`TCR_OFF_STATUS, 32'h3f);
    $display("test overflow done");
    wr(`TCR_OFF_CMP0, 32'h5);
    wr(`TCR_OFF_CMP1, 32'h5);
    wr(`TCR_OFF_RELOAD, 32'h0);
    wr(`TCR_OFF_COUNT, 32'h0);
    wr(`TCR_OFF_CMPMODE, 32'h23);
    wr(`TCR_OFF_PORT, 32'h7);
    repeat (2) @(negedge pclk);
    chk("pins before match", 32'h4, {28'h0, compare_out});
    wr(`TCR_OFF_CTRL, 32'h09);
    repeat (60) @(negedge pclk);
    chk("pins at match", 32'h7, {28'h0, compare_out});
    rdc("match flags", `TCR_OFF_STATUS, 32'hc);
    wr(`TCR_OFF_PORT, 32'h0);
    wr(`TCR_OFF_COUNT, 32'hfffa);
    wait_irq();
    chk("pins at overflow", 32'h2, {28'h0, compare_out});
    repeat (45) @(negedge pclk);
    chk("pins at next match", 32'h1, {28'h0, compare_out});
    $display("test compare done");
    wr(`TCR_OFF_RELOAD, 32'h1234abcd);
    rdc("reload width", `TCR_OFF_RELOAD, 32'habcd);
    wr(8'h1c, 32'hffffffff);
    chk("unmapped error", 32'h1, {31'h0, err});
    rdc("unmapped read", 8'h1c, 32'h0);
    rdc("unaligned read", 8'h02, 32'h0);
    chk("unaligned error", 32'h1, {31'h0, err});
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("pins in reset", 32'h0, {28'h0, compare_out});
    chk("irq in reset", 32'h0, {31'h0, irq});
    @(posedge pclk) presetn <= 1'b1;
    foreach (offs[i]) rdc("reset value", offs[i], 32'h0);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
